// [fms_float_sequencer.sv]
// Purpose: float mode measurement cycle sequencer with configuration registers
// Assumes: slot_start, adc_done and adc_data come from logic on mclk
// Notes: timing fields outside this register set arrive as plain inputs
`timescale 1ns/1ps
module fms_float_sequencer
  import fms_pkg::*;
(
  input  wire logic               mclk,
  input  wire logic               resetn,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  input  wire logic [7:0]         reg_addr,
  input  wire logic [15:0]        reg_wdata,
  output logic      [15:0]        reg_rdata,
  input  wire logic               slot_start,
  input  wire logic               slot_b_sel,
  input  wire fms_timing_t        timing_a,
  input  wire fms_timing_t        timing_b,
  input  wire logic [1:0]         cathode_legacy_a,
  input  wire logic [1:0]         cathode_legacy_b,
  input  wire logic               led_enable,
  input  wire logic               adc_done,
  input  wire logic [ADC_W-1:0]   adc_data,
  output fms_afe_t                afe,
  output fms_cfg_t                cfg,
  output logic                    busy,
  output logic signed [ACC_W-1:0] result,
  output logic                    result_valid
);

  typedef struct packed {
    fms_phase_t              phase;
    logic [15:0]             cnt;
    logic [7:0]              pulse;
    logic                    slot_b;
    logic signed [ACC_W-1:0] acc;
    logic signed [ACC_W-1:0] result;
    logic                    result_valid;
    logic [15:0]             rdata;
    logic [15:0]             emitter;
    logic [15:0]             a_ampref;
    logic [15:0]             a_route;
    logic [15:0]             b_ampref;
    logic [15:0]             b_route;
    logic [15:0]             cathode;
    logic [15:0]             arith;
    logic [15:0]             b_float;
    logic [15:0]             a_float;
  } fms_regs_t;

  fms_regs_t s;
  fms_regs_t next_s;

  function automatic logic [1:0] fld2(input logic [15:0] w, input int lsb);
    return w[lsb +: 2];
  endfunction : fld2

  function automatic logic slot_float_ok(input fms_regs_t r, input logic b);
    logic [1:0] emit;
    logic [1:0] en;
    emit = b ? fld2(r.emitter, EMIT_B_LSB) : fld2(r.emitter, EMIT_A_LSB);
    en   = b ? fld2(r.b_float, FLT_EN_LSB) : fld2(r.a_float, FLT_EN_LSB);
    return (emit == EMIT_FLOAT) && (en == FLT_EN_ON);
  endfunction : slot_float_ok

  // the precondition field is read at slot start and again between pulses
  function automatic logic [4:0] precon_field(input fms_regs_t r, input logic b);
    return b ? r.b_float[PRECON_LSB +: 5] : r.a_float[PRECON_LSB +: 5];
  endfunction : precon_field

  fms_timing_t             tim;
  logic [4:0]              precon_us;
  logic [1:0]              arith_sel;
  logic [9:0]              flt_us;
  logic [15:0]             float_len;
  logic [15:0]             last_pulse;
  logic signed [ACC_W-1:0] sample;

  always_comb begin
    tim        = s.slot_b ? timing_b : timing_a;
    precon_us  = precon_field(s, s.slot_b);
    arith_sel  = s.slot_b ? fld2(s.arith, ARITH_B_LSB) : fld2(s.arith, ARITH_A_LSB);
    // only the first pulse takes the short float time
    flt_us     = (s.pulse == 8'h00) ? tim.first_float_us : tim.float_us;
    // clamp keeps the phase arithmetic from wrapping on a bad setting
    if (flt_us < 10'(FLOAT_MIN_US)) begin
      flt_us = 10'(FLOAT_MIN_US);
    end
    float_len  = fms_cycles(flt_us) - (HALF_CYC + HALF_CYC) - CLEAR_CYC;
    last_pulse = (tim.pulses == 8'h00) ? 16'h0000 : {8'h00, tim.pulses - 8'h01};
    sample     = ACC_W'($signed({1'b0, adc_data}));
  end

  always_comb begin
    next_s              = s;
    next_s.result_valid = 1'b0;
    if (reg_wr) begin
      case (reg_addr)
        ADDR_EMITTER:  next_s.emitter  = reg_wdata;
        ADDR_A_AMPREF: next_s.a_ampref = reg_wdata;
        ADDR_A_ROUTE:  next_s.a_route  = reg_wdata;
        ADDR_B_AMPREF: next_s.b_ampref = reg_wdata;
        ADDR_B_ROUTE:  next_s.b_route  = reg_wdata;
        ADDR_CATHODE:  next_s.cathode  = reg_wdata;
        ADDR_ARITH:    next_s.arith    = reg_wdata;
        ADDR_B_FLOAT:  next_s.b_float  = reg_wdata;
        ADDR_A_FLOAT:  next_s.a_float  = reg_wdata;
        default:       next_s.rdata    = s.rdata;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        ADDR_EMITTER:  next_s.rdata = s.emitter;
        ADDR_A_AMPREF: next_s.rdata = s.a_ampref;
        ADDR_A_ROUTE:  next_s.rdata = s.a_route;
        ADDR_B_AMPREF: next_s.rdata = s.b_ampref;
        ADDR_B_ROUTE:  next_s.rdata = s.b_route;
        ADDR_CATHODE:  next_s.rdata = s.cathode;
        ADDR_ARITH:    next_s.rdata = s.arith;
        ADDR_B_FLOAT:  next_s.rdata = s.b_float;
        ADDR_A_FLOAT:  next_s.rdata = s.a_float;
        default:       next_s.rdata = REG_RESET;
      endcase
    end
    case (s.phase)
      S_IDLE: begin
        // a start on a slot not set up for float is ignored
        if (slot_start && slot_float_ok(s, slot_b_sel)) begin
          next_s.slot_b = slot_b_sel;
          next_s.pulse  = 8'h00;
          next_s.acc    = '0;
          next_s.phase  = S_PRECON;
          next_s.cnt    = fms_cycles({5'h00, precon_field(s, slot_b_sel)}) - 16'h0001;
        end
      end
      S_PRECON: begin
        if (s.cnt == 16'h0000) begin
          next_s.phase = S_FLOAT;
          next_s.cnt   = float_len - 16'h0001;
        end else begin
          next_s.cnt = s.cnt - 16'h0001;
        end
      end
      S_FLOAT: begin
        if (s.cnt == 16'h0000) begin
          next_s.phase = S_CLEAR;
          next_s.cnt   = CLEAR_CYC - 16'h0001;
        end else begin
          next_s.cnt = s.cnt - 16'h0001;
        end
      end
      S_CLEAR: begin
        next_s.phase = S_POS;
        next_s.cnt   = HALF_CYC - 16'h0001;
      end
      S_POS: begin
        if (s.cnt == 16'h0000) begin
          next_s.phase = S_NEGF;
          next_s.cnt   = HALF_CYC - 16'h0001;
        end else begin
          next_s.cnt = s.cnt - 16'h0001;
        end
      end
      S_NEGF: begin
        if (s.cnt == 16'h0000) begin
          next_s.phase = S_DUMP;
          next_s.cnt   = fms_cycles({5'h00, tim.connect_us}) - 16'h0001;
        end else begin
          next_s.cnt = s.cnt - 16'h0001;
        end
      end
      S_DUMP: begin
        if (s.cnt == 16'h0000) begin
          next_s.phase = S_TAIL;
          next_s.cnt   = HALF_CYC - 16'h0001;
        end else begin
          next_s.cnt = s.cnt - 16'h0001;
        end
      end
      S_TAIL: begin
        if (s.cnt == 16'h0000) begin
          next_s.phase = S_HOLD;
        end else begin
          next_s.cnt = s.cnt - 16'h0001;
        end
      end
      S_HOLD: begin
        if (adc_done) begin
          // first pulse subtracted under the sub/add setting, all others summed
          if ((s.pulse == 8'h00) && (arith_sel == ARITH_SUB_ADD)) begin
            next_s.acc = s.acc - sample;
          end else begin
            next_s.acc = s.acc + sample;
          end
          if ({8'h00, s.pulse} >= last_pulse) begin
            next_s.result       = (s.pulse == 8'h00 && arith_sel == ARITH_SUB_ADD) ? s.acc - sample
                                                                                  : s.acc + sample;
            next_s.result_valid = 1'b1;
            next_s.phase        = S_IDLE;
          end else begin
            next_s.pulse = s.pulse + 8'h01;
            next_s.phase = S_PRECON;
            next_s.cnt   = fms_cycles({5'h00, precon_us}) - 16'h0001;
          end
        end
      end
      default: next_s.phase = S_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      s <= '{phase: S_IDLE, cnt: 16'h0000, pulse: 8'h00, slot_b: 1'b0, acc: '0, result: '0,
             result_valid: 1'b0, rdata: REG_RESET, emitter: REG_RESET, a_ampref: REG_RESET,
             a_route: REG_RESET, b_ampref: REG_RESET, b_route: REG_RESET, cathode: REG_RESET,
             arith: REG_RESET, b_float: REG_RESET, a_float: REG_RESET};
    end else begin
      s <= next_s;
    end
  end

  always_comb begin
    afe.pd_connect  = (s.phase == S_PRECON) || (s.phase == S_DUMP);
    afe.tia_connect = (s.phase == S_PRECON) || (s.phase == S_DUMP);
    afe.int_clear   = (s.phase == S_CLEAR);
    afe.int_pos     = (s.phase == S_POS);
    afe.int_neg     = (s.phase == S_NEGF) || (s.phase == S_DUMP) || (s.phase == S_TAIL);
    afe.int_hold    = (s.phase == S_HOLD);
    // LED window is the whole float span, A up to D
    afe.led_fire    = led_enable && ((s.phase == S_FLOAT) || (s.phase == S_CLEAR) ||
                                     (s.phase == S_POS) || (s.phase == S_NEGF));
  end

  always_comb begin
    cfg.bpf_bypass_a  = (s.a_route == ROUTE_FLOAT);
    cfg.bpf_bypass_b  = (s.b_route == ROUTE_FLOAT);
    cfg.amp_ref_09v_a = (fld2(s.a_ampref, AMPREF_LSB) == AMPREF_0V9);
    cfg.amp_ref_09v_b = (fld2(s.b_ampref, AMPREF_LSB) == AMPREF_0V9);
    // value two of the selected field means 250 mV reverse bias
    cfg.cathode_sel_a = s.cathode[CATH_OVR_BIT] ? fld2(s.cathode, CATH_A_LSB) : cathode_legacy_a;
    cfg.cathode_sel_b = s.cathode[CATH_OVR_BIT] ? fld2(s.cathode, CATH_B_LSB) : cathode_legacy_b;
  end

  assign reg_rdata    = s.rdata;
  assign busy         = (s.phase != S_IDLE);
  assign result       = s.result;
  assign result_valid = s.result_valid;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);

  sequence clear_then_pos;
    afe.int_clear ##1 (afe.int_pos && !afe.pd_connect);
  endsequence

  sequence pos_then_neg;
    afe.int_pos ##25 (afe.int_neg && !afe.pd_connect);
  endsequence

  sequence tail_then_hold;
    (afe.int_neg && !afe.tia_connect) ##1 (afe.int_hold && !afe.int_neg);
  endsequence

  sequence precon_entry;
    (s.phase == S_PRECON) && (s.pulse == 8'h00) && (s.acc == '0);
  endsequence

  float_select_a: assert property (
    (s.phase == S_IDLE && slot_start && !slot_float_ok(s, slot_b_sel)) |=> (s.phase == S_IDLE))
    else $error("start accepted on a slot not in float mode");

  precon_state_a: assert property (
    (s.phase == S_PRECON) |-> (afe.pd_connect && afe.tia_connect && !afe.int_pos && !afe.int_neg))
    else $error("precondition connection or integrator wrong");

  float_open_a: assert property (
    $rose(s.phase == S_FLOAT) |-> (!afe.pd_connect && !afe.tia_connect && $past(afe.pd_connect)))
    else $error("float start did not disconnect photodiode");

  clear_pos_a: assert property (
    $rose(afe.int_clear) |-> clear_then_pos)
    else $error("integrator clear not followed by positive phase");

  pos_len_a: assert property (
    $rose(afe.int_pos) |-> pos_then_neg)
    else $error("negative phase not started after positive phase");

  dump_start_a: assert property (
    (s.phase == S_NEGF && s.cnt == 16'h0000) |=> (afe.pd_connect && afe.int_neg))
    else $error("photodiode not reconnected in negative phase");

  tail_open_a: assert property (
    (s.phase == S_DUMP && s.cnt == 16'h0000) |=> (!afe.tia_connect && afe.int_neg))
    else $error("amplifier not released for negative tail");

  hold_wait_a: assert property (
    (afe.int_hold && !adc_done) |=> afe.int_hold)
    else $error("integrator hold dropped before ADC sample");

  led_window_a: assert property (
    afe.led_fire |-> (!afe.pd_connect && !afe.int_hold && s.phase != S_TAIL))
    else $error("LED fired outside float window");

  first_sub_a: assert property (
    (s.phase == S_HOLD && adc_done && s.pulse == 8'h00 && arith_sel == ARITH_SUB_ADD)
      |=> (s.acc == $past(s.acc) - $past(sample)))
    else $error("first pulse not subtracted");

  result_once_a: assert property (
    s.result_valid |-> (s.phase == S_IDLE && $past(s.phase) == S_HOLD) ##1 !s.result_valid)
    else $error("result delivered outside end of sample");

  start_take_a: assert property (
    (s.phase == S_IDLE && slot_start && slot_float_ok(s, slot_b_sel)) |=> precon_entry)
    else $error("float slot start not taken");

  precon_quiet_a: assert property (
    (s.phase == S_PRECON) |-> (!afe.int_clear && !afe.int_hold && !afe.led_fire))
    else $error("integrator active during precondition");

  pos_float_a: assert property (
    afe.int_pos |-> (!afe.pd_connect && !afe.tia_connect))
    else $error("positive phase ran with photodiode connected");

  tail_end_a: assert property (
    (s.phase == S_TAIL && s.cnt == 16'h0000) |-> tail_then_hold)
    else $error("negative tail did not end in hold");

  hold_quiet_a: assert property (
    afe.int_hold |-> (!afe.int_pos && !afe.int_neg && !afe.pd_connect && !afe.tia_connect))
    else $error("integrator not frozen during hold");

  rest_add_a: assert property (
    (s.phase == S_HOLD && adc_done && !(s.pulse == 8'h00 && arith_sel == ARITH_SUB_ADD))
      |=> (s.acc == $past(s.acc) + $past(sample)))
    else $error("later pulse not added to accumulator");

  result_acc_a: assert property (
    s.result_valid |-> (s.result == s.acc))
    else $error("delivered result differs from accumulator");

  // led mode is a level request; firing without it would bias an ambient result
  led_gate_a: assert property (
    afe.led_fire |-> led_enable)
    else $error("LED fired without LED mode");

endmodule : fms_float_sequencer

// [fms_pkg.sv]
// Purpose: constants, types and helpers for the float mode sequencer
// Assumes: 25 MHz mclk, 16-bit registers at 8-bit addresses
// Notes:
// Operation
// - slot uses float mode when its emitter select field reads zero
// - float between connect pulses enabled when slot float enable equals three
// - first-pair arithmetic value two subtracts first pulse, adds second
// - routing word 0xAE65 passes amplifier and integrator, bypasses band-pass filter
// - amplifier reference value two selects the 0.9 V setting
// - cathode select value two gives 250 mV reverse bias at precondition
// - cathode override bit set makes per-slot cathode fields win over legacy
// - during precondition the photodiode stays connected to the amplifier
// - integrator stays off throughout precondition
// - float start disconnects photodiode and amplifier from receive path
// - integrator is cleared right before positive phase
// - positive integration starts while photodiode still floats
// - negative phase begins after positive phase, before reconnection
// - photodiode reconnects during negative phase to dump charge
// - amplifier disconnects while integrator finishes negative phase
// - integrator output held after negative phase until ADC samples
// - LED fires only between float start and reconnection
// - only the first pulse may be short; later pulses share one length
// - differential ambient result is second measurement minus first
// - without drift cancel any pulse count is allowed and summed
// - precondition duration programmable per slot in float control bits 12:8
package fms_pkg;
  localparam logic [7:0]  ADDR_EMITTER    = 8'h14;
  localparam logic [7:0]  ADDR_A_AMPREF   = 8'h42;
  localparam logic [7:0]  ADDR_A_ROUTE    = 8'h43;
  localparam logic [7:0]  ADDR_B_AMPREF   = 8'h44;
  localparam logic [7:0]  ADDR_B_ROUTE    = 8'h45;
  localparam logic [7:0]  ADDR_CATHODE    = 8'h54;
  localparam logic [7:0]  ADDR_ARITH      = 8'h58;
  localparam logic [7:0]  ADDR_B_FLOAT    = 8'h59;
  localparam logic [7:0]  ADDR_A_FLOAT    = 8'h5E;
  localparam logic [15:0] REG_RESET       = 16'h0000;
  localparam int          EMIT_A_LSB      = 0;
  localparam int          EMIT_B_LSB      = 2;
  localparam int          FLT_EN_LSB      = 13;
  localparam int          PRECON_LSB      = 8;
  localparam int          ARITH_A_LSB     = 1;
  localparam int          ARITH_B_LSB     = 5;
  localparam int          AMPREF_LSB      = 4;
  localparam int          CATH_A_LSB      = 8;
  localparam int          CATH_B_LSB      = 10;
  localparam int          CATH_OVR_BIT    = 7;
  localparam logic [1:0]  EMIT_FLOAT      = 2'h0;
  localparam logic [1:0]  FLT_EN_ON       = 2'h3;
  localparam logic [1:0]  ARITH_SUB_ADD   = 2'h2;
  localparam logic [1:0]  AMPREF_0V9      = 2'h2;
  localparam logic [1:0]  CATH_250MV      = 2'h2;
  localparam logic [15:0] ROUTE_FLOAT     = 16'hAE65;
  localparam int          CLK_PERIOD_NS   = 40;
  localparam int          NS_PER_US       = 1000;
  localparam int          CYC_PER_US      = NS_PER_US / CLK_PERIOD_NS;
  localparam int          FLOAT_MIN_US    = 4;
  localparam int          INT_HALF_NS     = 1000;
  localparam logic [15:0] HALF_CYC        = 16'(INT_HALF_NS / CLK_PERIOD_NS);
  localparam logic [15:0] CLEAR_CYC       = 16'h0001;
  localparam int          ACC_W           = 20;
  localparam int          ADC_W           = 14;

  typedef enum logic [3:0] {S_IDLE, S_PRECON, S_FLOAT, S_CLEAR, S_POS, S_NEGF, S_DUMP, S_TAIL, S_HOLD} fms_phase_t;

  typedef struct packed {
    logic [7:0] pulses;
    logic [9:0] first_float_us;
    logic [9:0] float_us;
    logic [4:0] connect_us;
  } fms_timing_t;

  typedef struct packed {
    logic pd_connect;
    logic tia_connect;
    logic int_clear;
    logic int_pos;
    logic int_neg;
    logic int_hold;
    logic led_fire;
  } fms_afe_t;

  typedef struct packed {
    logic       bpf_bypass_a;
    logic       bpf_bypass_b;
    logic       amp_ref_09v_a;
    logic       amp_ref_09v_b;
    logic [1:0] cathode_sel_a;
    logic [1:0] cathode_sel_b;
  } fms_cfg_t;

  function automatic logic [15:0] fms_cycles(input logic [9:0] us);
    return (us == 10'h000) ? 16'h0001 : 16'(us * CYC_PER_US);
  endfunction : fms_cycles
endpackage : fms_pkg

// [fms_adc_model.sv]
// Purpose: ADC stand-in that samples the held integrator output
// Assumes: afe comes from the sequencer on mclk
// Notes: between conversions the data lines show the inverse of the last word
`timescale 1ns/1ps
module fms_adc_model
  import fms_pkg::*;
(
  input  wire logic             mclk,
  input  wire logic             resetn,
  input  wire fms_afe_t         afe,
  input  wire logic [3:0]       delay,
  input  wire logic [ADC_W-1:0] value,
  output logic                  adc_done,
  output logic      [ADC_W-1:0] adc_data
);
  logic [3:0] wait_cnt;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      adc_done <= 1'b0;
      adc_data <= '0;
      wait_cnt <= '0;
    end else if (adc_done) begin
      adc_done <= 1'b0;
      adc_data <= ~adc_data;
      wait_cnt <= '0;
    end else if (afe.int_hold) begin
      // slow answers stretch the hold on purpose
      if (wait_cnt == delay) begin
        adc_done <= 1'b1;
        adc_data <= value;
      end else begin
        wait_cnt <= wait_cnt + 4'h1;
      end
    end
  end
endmodule : fms_adc_model

// [tb.sv]
// Purpose: self-checking bench for the float mode sequencer
// Assumes: ADC stand-in answers each hold after a random delay
// Notes: inputs change and outputs are sampled on the falling edge
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin err_count++; $display("[ERR] t=%0t got=%0h exp=%0h", $time, g, e); end end
module tb;
  import fms_pkg::*;
  logic                    mclk, resetn, reg_wr, reg_rd, slot_start, slot_b_sel, led_enable, adc_done, busy, result_valid;
  logic [7:0]              reg_addr;
  logic [15:0]             reg_wdata, reg_rdata;
  logic [1:0]              cathode_legacy_a, cathode_legacy_b;
  logic [3:0]              adc_delay;
  logic [ADC_W-1:0]        adc_data, adc_value;
  logic signed [ACC_W-1:0] result;
  fms_timing_t             timing_a, timing_b;
  fms_afe_t                afe, prev_afe;
  fms_cfg_t                cfg;
  logic                    prev_done;
  logic [31:0]             seed;
  logic [ADC_W-1:0]        vals[$];
  int                      fspan[$], pspan[$];
  int                      err_count, total_checks, fcnt, pcnt, led_cnt;
  logic [7:0]              all_ad[9] = '{8'h14, 8'h42, 8'h43, 8'h44, 8'h45, 8'h54, 8'h58, 8'h59, 8'h5E};

  fms_float_sequencer dut_u (.mclk(mclk), .resetn(resetn), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .slot_start(slot_start), .slot_b_sel(slot_b_sel),
    .timing_a(timing_a), .timing_b(timing_b), .cathode_legacy_a(cathode_legacy_a),
    .cathode_legacy_b(cathode_legacy_b), .led_enable(led_enable), .adc_done(adc_done), .adc_data(adc_data),
    .afe(afe), .cfg(cfg), .busy(busy), .result(result), .result_valid(result_valid));
  fms_adc_model adc_u (.mclk(mclk), .resetn(resetn), .afe(afe), .delay(adc_delay), .value(adc_value),
    .adc_done(adc_done), .adc_data(adc_data));

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  // pulse 0 is subtracted only under the sub/add setting, every other pulse is added
  function automatic logic signed [ACC_W-1:0] exp_sum(input logic [1:0] ar);
    logic signed [ACC_W-1:0] acc;
    acc = '0;
    foreach (vals[i]) acc += (i == 0 && ar == ARITH_SUB_ADD) ? -ACC_W'(vals[i]) : ACC_W'(vals[i]);
    return acc;
  endfunction : exp_sum

  task automatic final_report();
    $display("checks=%0d mismatches=%0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : final_report

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge mclk);
    {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
    @(negedge mclk);
    reg_wr = 1'b0;
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
    @(negedge mclk);
    {reg_rd, reg_addr} = {1'b1, a};
    @(negedge mclk);
    reg_rd = 1'b0;
    @(negedge mclk);
    `CHK(reg_rdata, e)
  endtask : rd_chk

  task automatic cfg_test(input bit corner);
    logic [7:0]  ad[5];
    logic [15:0] v[5];
    ad = '{ADDR_A_ROUTE, ADDR_B_ROUTE, ADDR_A_AMPREF, ADDR_B_AMPREF, ADDR_CATHODE};
    foreach (v[i]) v[i] = 16'(rnd());
    if (corner) v = '{ROUTE_FLOAT, ROUTE_FLOAT, 16'h0020, 16'h0020, 16'h0A80};
    {cathode_legacy_a, cathode_legacy_b} = 4'(rnd());
    foreach (v[i]) wr(ad[i], v[i]);
    foreach (v[i]) rd_chk(ad[i], v[i]);
    `CHK(cfg.bpf_bypass_a, v[0] == ROUTE_FLOAT)
    `CHK(cfg.bpf_bypass_b, v[1] == ROUTE_FLOAT)
    `CHK(cfg.amp_ref_09v_a, v[2][5:4] == AMPREF_0V9)
    `CHK(cfg.amp_ref_09v_b, v[3][5:4] == AMPREF_0V9)
    `CHK(cfg.cathode_sel_a, v[4][CATH_OVR_BIT] ? v[4][9:8] : cathode_legacy_a)
    `CHK(cfg.cathode_sel_b, v[4][CATH_OVR_BIT] ? v[4][11:10] : cathode_legacy_b)
    $display("config test done");
  endtask : cfg_test

  task automatic pulse_start();
    @(negedge mclk);
    slot_start = 1'b1;
    @(negedge mclk);
    slot_start = 1'b0;
  endtask : pulse_start

  task automatic refuse(input logic [7:0] a, input logic [15:0] d);
    wr(a, d);
    pulse_start();
    repeat (3) @(negedge mclk);
    `CHK(busy, 1'b0)
  endtask : refuse

  task automatic run_slot(input bit b, input int np, input logic [1:0] ar, input bit led);
    logic [4:0]              pre;
    logic [9:0]              f1, f2;
    logic signed [ACC_W-1:0] exp;
    fms_timing_t             t;
    int                      n;
    pre = 5'(1 + rnd() % 3);
    f1 = 10'(FLOAT_MIN_US + rnd() % 4);
    f2 = 10'(8 + rnd() % 8);
    t = '{pulses: 8'(np), first_float_us: f1, float_us: f2, connect_us: 5'h02};
    if (b) timing_b = t;
    else timing_a = t;
    wr(ADDR_EMITTER, b ? 16'h0003 : 16'h000C);
    wr(b ? ADDR_B_FLOAT : ADDR_A_FLOAT, {1'b0, FLT_EN_ON, pre, 8'h00});
    wr(ADDR_ARITH, b ? {9'h000, ar, 5'h00} : {13'h0000, ar, 1'b0});
    {slot_b_sel, led_enable, adc_delay, adc_value} = {b, led, 4'(rnd()), 14'h3FFF};
    vals.delete();
    fspan.delete();
    pspan.delete();
    led_cnt = 0;
    pulse_start();
    `CHK(busy, 1'b1)
    repeat (20) @(negedge mclk);
    pulse_start();
    n = 0;
    while (result_valid !== 1'b1) begin
      @(negedge mclk);
      n++;
      if (n > 30000) begin
        err_count++;
        final_report();
      end
    end
    exp = exp_sum(ar);
    `CHK(result, exp)
    `CHK(vals.size(), np)
    `CHK(fspan.size(), np)
    foreach (fspan[i]) `CHK(fspan[i], (i == 0 ? f1 : f2) * CYC_PER_US)
    foreach (pspan[i]) `CHK(pspan[i], pre * CYC_PER_US)
    `CHK(led_cnt > 0, led)
    $display("slot run done: slot %0d pulses %0d", b, np);
  endtask : run_slot

  // phase spans and ordering are measured on the afe levels, not inferred from timing
  always @(negedge mclk) begin
    if (afe.pd_connect && afe.tia_connect && !afe.int_neg) pcnt++;
    else if (pcnt > 0) begin
      pspan.push_back(pcnt);
      pcnt = 0;
    end
    if (fcnt > 0 && !afe.pd_connect) fcnt++;
    else if (fcnt > 0) begin
      fspan.push_back(fcnt);
      fcnt = 0;
    end
    if (prev_afe.pd_connect && !prev_afe.int_neg && !afe.pd_connect) fcnt = 1;
    if (busy === 1'b1) begin
      `CHK(afe.led_fire & afe.pd_connect, 1'b0)
      `CHK(afe.pd_connect & (afe.int_pos | afe.int_clear | afe.int_hold), 1'b0)
      `CHK(afe.tia_connect, afe.pd_connect)
      if (afe.int_pos && !prev_afe.int_pos) `CHK(prev_afe.int_clear, 1'b1)
      if (afe.int_neg && !prev_afe.int_neg) `CHK(prev_afe.int_pos, 1'b1)
    end
    if (prev_afe.int_hold && !afe.int_hold) `CHK(prev_done, 1'b1)
    if (afe.led_fire === 1'b1) led_cnt++;
    if (adc_done === 1'b1) begin
      vals.push_back(adc_data);
      adc_value <= 14'(rnd());
    end
    prev_afe = afe;
    prev_done = adc_done;
  end

  initial begin
    {resetn, reg_wr, reg_rd, reg_addr, reg_wdata, slot_start, slot_b_sel, led_enable} = '0;
    {cathode_legacy_a, cathode_legacy_b, adc_delay, adc_value, timing_a, timing_b} = '0;
    {prev_afe, prev_done, err_count, total_checks, fcnt, pcnt, led_cnt} = '0;
    seed = 32'hF8EE;
    repeat (20) @(negedge mclk);
    resetn = 1'b1;
    foreach (all_ad[i]) rd_chk(all_ad[i], REG_RESET);
    `CHK(cfg, fms_cfg_t'(8'h00))
    for (int i = 0; i < 4; i++) cfg_test(i == 0);
    wr(8'h15, 16'hFFFF);
    rd_chk(8'h15, 16'h0000);
    for (int b = 0; b < 2; b++) begin
      run_slot(b[0], 2, ARITH_SUB_ADD, b[0]);
      for (int k = 0; k < 3; k++) refuse(b ? ADDR_B_FLOAT : ADDR_A_FLOAT, {1'b0, 2'(k), 13'h0100});
      wr(b ? ADDR_B_FLOAT : ADDR_A_FLOAT, 16'h6100);
      for (int k = 1; k < 4; k++) refuse(ADDR_EMITTER, b ? 16'(k << 2) : 16'(k));
    end
    run_slot(1'b0, 3, 2'h0, 1'b1);
    run_slot(1'b1, 1, 2'h0, 1'b0);
    for (int i = 0; i < 4; i++) run_slot(rnd() % 2 == 1, 1 + rnd() % 4, 2'(rnd()), rnd() % 2 == 1);
    // reset in mid-slot must drop the sequence and clear the result and the emitter register
    pulse_start();
    `CHK(busy, 1'b1)
    repeat (40) @(negedge mclk);
    resetn = 1'b0;
    repeat (2) @(negedge mclk);
    resetn = 1'b1;
    `CHK(busy, 1'b0)
    `CHK(result, '0)
    rd_chk(ADDR_EMITTER, REG_RESET);
    $display("mid-run reset test done");
    final_report();
  end
endmodule : tb
